// ==== src/verb_ring_dma.sv ====
// command and response ring engine with avalon-mm registers
// assumes a memory master that holds mem_req until one mem_ack pulse
// Behaviour
// - command ring size selects 2, 16 or 256 four-byte entries.
// - command indices count whole commands; byte offset is index times four.
// - while running, fetch commands whenever read index differs from write index.
// - each fetched command goes out at the start of one link frame; one fetched with mem_err set is dropped and a null command goes out.
// - read index advances per fetch; fetching stops when indices match.
// - write index moves while running are followed; new commands sent too.
// - command ring base lower seven bits always read zero.
// - command words are 32 bits and passed on uninterpreted.
// - response ring size selects 2, 16 or 256 eight-byte entries.
// - every response is written blindly; hardware keeps only a write index.
// - interrupt after N responses or an all-empty response slot.
// - entry word 0 is the codec response, word 1 the extension.
// - extension bits 3:0 carry the input line index.
// - extension bit 4 is 1 for unsolicited, 0 for solicited.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`default_nettype none
module verb_ring_dma import verb_ring_pkg::*; #(
  parameter int AVS_ADDR_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic mem_req,
  output logic mem_write,
  output logic [63:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic mem_err,
  input wire logic [31:0] mem_rdata,
  input wire logic link_bclk,
  input wire logic link_frame_sync,
  input wire logic [31:0] resp_word_pins,
  input wire logic [3:0] resp_line_pins,
  input wire logic resp_unsol_pin,
  input wire logic resp_present_pin,
  input wire logic resp_slot_empty_pin,
  output logic cmd_sdo,
  output logic irq
);
  generate
    if (AVS_ADDR_W < 4) begin : g_bad_width
      $error("avs address too narrow for the register map");
    end
  endgenerate

  // index mask for a ring size code; reserved code never stored
  function automatic logic [7:0] size_mask(input logic [1:0] code);
    if (code == SIZE_16) begin
      return 8'h0f;
    end else if (code == SIZE_256) begin
      return 8'hff;
    end else begin
      return 8'h01;
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  link_events_if ev ();

  link_rx_sync u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .link_bclk(link_bclk),
    .link_frame_sync(link_frame_sync),
    .resp_word_pins(resp_word_pins),
    .resp_line_pins(resp_line_pins),
    .resp_unsol_pin(resp_unsol_pin),
    .resp_present_pin(resp_present_pin),
    .resp_slot_empty_pin(resp_slot_empty_pin),
    .ev(ev)
  );

  cmd_serializer u_ser (
    .clk(clk),
    .rst_n(rst_n),
    .ev(ev),
    .cmd_sdo(cmd_sdo)
  );

  // software-visible state
  logic [31:0] cmd_base_lo;
  logic [31:0] cmd_base_hi;
  logic [7:0] cmd_wr_idx;
  logic [7:0] cmd_rd_idx;
  logic cmd_run;
  logic cmd_irq_en;
  logic [1:0] cmd_size;
  logic [31:0] rsp_base_lo;
  logic [31:0] rsp_base_hi;
  logic [7:0] rsp_wr_idx;
  logic [1:0] rsp_size;
  logic [7:0] rsp_count_n;
  logic rsp_run;
  logic rsp_irq_en;
  logic rsp_flag;
  logic mem_err_flag;
  logic served;
  // engine state
  dma_state_t state;
  logic cmd_full;
  logic [31:0] cmd_hold;
  logic rsp_pend;
  logic [31:0] rsp_word;
  logic [4:0] rsp_ext;
  logic [7:0] rsp_count;

  logic [31:0] next_cmd_base_lo, next_cmd_base_hi;
  logic [7:0] next_cmd_wr_idx, next_cmd_rd_idx;
  logic next_cmd_run, next_cmd_irq_en;
  logic [1:0] next_cmd_size, next_rsp_size;
  logic [31:0] next_rsp_base_lo, next_rsp_base_hi;
  logic [7:0] next_rsp_wr_idx, next_rsp_count_n, next_rsp_count;
  logic next_rsp_run, next_rsp_irq_en, next_rsp_flag, next_mem_err_flag;
  logic next_served;
  logic [31:0] next_readdata;
  dma_state_t next_state;
  logic next_cmd_full, next_rsp_pend;
  logic [31:0] next_cmd_hold, next_rsp_word;
  logic [4:0] next_rsp_ext;
  logic [31:0] rd_value;
  logic [31:0] wv;
  logic wr;
  logic [7:0] cmd_next_idx, rsp_next_idx;
  logic rsp_set, mem_err_set;
  logic [3:0] reg_idx;

  assign reg_idx = avs_address[3:0];
  assign avs_waitrequest = (avs_read | avs_write) & ~served;
  assign wr = avs_write & served;
  assign cmd_next_idx = (cmd_rd_idx + 8'h01) & size_mask(cmd_size);
  assign rsp_next_idx = (rsp_wr_idx + 8'h01) & size_mask(rsp_size);
  assign ev.cmd_word = cmd_full ? cmd_hold : NULL_COMMAND;
  assign irq = (rsp_flag & rsp_irq_en) | (mem_err_flag & cmd_irq_en);

  // register read mux
  always_comb begin
    rd_value = 32'h00000000;
    if (AVS_ADDR_W > 4 && avs_address >= AVS_ADDR_W'(16)) begin
      rd_value = 32'h00000000;
    end else if (reg_idx == REG_CMD_BASE_LO) begin
      rd_value = cmd_base_lo;
    end else if (reg_idx == REG_CMD_BASE_HI) begin
      rd_value = cmd_base_hi;
    end else if (reg_idx == REG_CMD_WR_IDX) begin
      rd_value[7:0] = cmd_wr_idx;
    end else if (reg_idx == REG_CMD_RD_IDX) begin
      rd_value[7:0] = cmd_rd_idx;
    end else if (reg_idx == REG_CMD_CTRL) begin
      rd_value[CTRL_RUN_BIT] = cmd_run;
      rd_value[CTRL_IRQ_EN_BIT] = cmd_irq_en;
    end else if (reg_idx == REG_CMD_SIZE) begin
      rd_value[1:0] = cmd_size;
      rd_value[SIZE_CAP_LSB +: 4] = SIZE_CAPABILITY;
    end else if (reg_idx == REG_RSP_BASE_LO) begin
      rd_value = rsp_base_lo;
    end else if (reg_idx == REG_RSP_BASE_HI) begin
      rd_value = rsp_base_hi;
    end else if (reg_idx == REG_RSP_WR_IDX) begin
      rd_value[7:0] = rsp_wr_idx;
    end else if (reg_idx == REG_RSP_SIZE) begin
      rd_value[1:0] = rsp_size;
      rd_value[SIZE_CAP_LSB +: 4] = SIZE_CAPABILITY;
    end else if (reg_idx == REG_RSP_COUNT) begin
      rd_value[7:0] = rsp_count_n;
    end else if (reg_idx == REG_RSP_CTRL) begin
      rd_value[CTRL_RUN_BIT] = rsp_run;
      rd_value[CTRL_IRQ_EN_BIT] = rsp_irq_en;
    end else if (reg_idx == REG_STATUS) begin
      rd_value[STAT_RSP_BIT] = rsp_flag;
      rd_value[STAT_MEM_ERR_BIT] = mem_err_flag;
    end
  end

  // next values of registers and engine
  always_comb begin
    next_cmd_base_lo = cmd_base_lo;
    next_cmd_base_hi = cmd_base_hi;
    next_cmd_wr_idx = cmd_wr_idx;
    next_cmd_rd_idx = cmd_rd_idx;
    next_cmd_run = cmd_run;
    next_cmd_irq_en = cmd_irq_en;
    next_cmd_size = cmd_size;
    next_rsp_base_lo = rsp_base_lo;
    next_rsp_base_hi = rsp_base_hi;
    next_rsp_wr_idx = rsp_wr_idx;
    next_rsp_size = rsp_size;
    next_rsp_count_n = rsp_count_n;
    next_rsp_count = rsp_count;
    next_rsp_run = rsp_run;
    next_rsp_irq_en = rsp_irq_en;
    next_served = (avs_read | avs_write) & ~served;
    next_readdata = (avs_read & ~served) ? rd_value : avs_readdata;
    next_state = state;
    next_cmd_full = cmd_full;
    next_cmd_hold = cmd_hold;
    next_rsp_pend = rsp_pend;
    next_rsp_word = rsp_word;
    next_rsp_ext = rsp_ext;
    rsp_set = 1'b0;
    mem_err_set = 1'b0;
    wv = merge(rd_value, avs_writedata, avs_byteenable);
    mem_req = 1'b0;
    mem_write = 1'b0;
    mem_addr = 64'h0;
    mem_wdata = 32'h00000000;

    // frame start hands the held command to the serializer
    if (ev.frame_start) begin
      next_cmd_full = 1'b0;
      if (ev.resp_present && rsp_run) begin
        next_rsp_pend = 1'b1;
        next_rsp_word = ev.resp_word;
        next_rsp_ext = {ev.resp_unsol, ev.resp_line};
      end
      if (ev.resp_empty_all && rsp_run) begin
        rsp_set = 1'b1;
        next_rsp_count = 8'h00;
      end
    end

    case (state)
      st_idle: begin
        if (rsp_pend) begin
          next_state = st_resp_lo;
        end else if (cmd_run && cmd_rd_idx != cmd_wr_idx && !cmd_full) begin
          next_state = st_fetch;
        end
      end
      st_fetch: begin
        mem_req = 1'b1;
        mem_addr = {cmd_base_hi, cmd_base_lo[31:7], BASE_ALIGN_ZERO}
          + {54'h0, cmd_next_idx, 2'b00};
        if (mem_ack) begin
          next_cmd_rd_idx = cmd_next_idx;
          next_cmd_hold = mem_rdata;
          next_cmd_full = !mem_err;
          mem_err_set = mem_err;
          next_state = st_idle;
        end
      end
      st_resp_lo: begin
        mem_req = 1'b1;
        mem_write = 1'b1;
        mem_addr = {rsp_base_hi, rsp_base_lo[31:7], BASE_ALIGN_ZERO}
          + {53'h0, rsp_next_idx, 3'b000};
        mem_wdata = rsp_word;
        if (mem_ack) begin
          next_state = st_resp_hi;
        end
      end
      st_resp_hi: begin
        mem_req = 1'b1;
        mem_write = 1'b1;
        mem_addr = {rsp_base_hi, rsp_base_lo[31:7], BASE_ALIGN_ZERO}
          + {53'h0, rsp_next_idx, 3'b100};
        mem_wdata = {27'h0, rsp_ext};
        if (mem_ack) begin
          next_rsp_wr_idx = rsp_next_idx;
          next_rsp_pend = ev.frame_start & ev.resp_present & rsp_run;
          next_rsp_count = rsp_count + 8'h01;
          if (rsp_count + 8'h01 == rsp_count_n) begin
            rsp_set = 1'b1;
            next_rsp_count = 8'h00;
          end
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase

    // register writes take effect at the edge after the one that ends the wait, when the transfer completes
    if (wr && (AVS_ADDR_W == 4 || avs_address < AVS_ADDR_W'(16))) begin
      if (reg_idx == REG_CMD_BASE_LO) begin
        next_cmd_base_lo = {wv[31:7], BASE_ALIGN_ZERO};
      end else if (reg_idx == REG_CMD_BASE_HI) begin
        next_cmd_base_hi = wv;
      end else if (reg_idx == REG_CMD_WR_IDX) begin
        next_cmd_wr_idx = wv[7:0] & size_mask(cmd_size);
      end else if (reg_idx == REG_CMD_RD_IDX) begin
        if (wv[IDX_RST_BIT]) begin
          next_cmd_rd_idx = 8'h00;
        end
      end else if (reg_idx == REG_CMD_CTRL) begin
        next_cmd_run = wv[CTRL_RUN_BIT];
        next_cmd_irq_en = wv[CTRL_IRQ_EN_BIT];
        if (wv[CTRL_IDX_RST_BIT]) begin
          next_cmd_rd_idx = 8'h00;
        end
      end else if (reg_idx == REG_CMD_SIZE) begin
        if (wv[1:0] != 2'h3) begin
          next_cmd_size = wv[1:0];
        end
      end else if (reg_idx == REG_RSP_BASE_LO) begin
        next_rsp_base_lo = {wv[31:7], BASE_ALIGN_ZERO};
      end else if (reg_idx == REG_RSP_BASE_HI) begin
        next_rsp_base_hi = wv;
      end else if (reg_idx == REG_RSP_WR_IDX) begin
        if (wv[IDX_RST_BIT]) begin
          next_rsp_wr_idx = 8'h00;
        end
      end else if (reg_idx == REG_RSP_SIZE) begin
        if (wv[1:0] != 2'h3) begin
          next_rsp_size = wv[1:0];
        end
      end else if (reg_idx == REG_RSP_COUNT) begin
        next_rsp_count_n = wv[7:0];
        next_rsp_count = 8'h00;
      end else if (reg_idx == REG_RSP_CTRL) begin
        next_rsp_run = wv[CTRL_RUN_BIT];
        next_rsp_irq_en = wv[CTRL_IRQ_EN_BIT];
      end
    end
    // sticky flags: a new event beats a same-cycle clear
    next_rsp_flag = rsp_flag;
    next_mem_err_flag = mem_err_flag;
    if (wr && reg_idx == REG_STATUS) begin
      if (avs_byteenable[0] && avs_writedata[STAT_RSP_BIT]) begin
        next_rsp_flag = 1'b0;
      end
      if (avs_byteenable[0] && avs_writedata[STAT_MEM_ERR_BIT]) begin
        next_mem_err_flag = 1'b0;
      end
    end
    next_rsp_flag = next_rsp_flag | rsp_set;
    next_mem_err_flag = next_mem_err_flag | mem_err_set;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_base_lo <= 32'h00000000;
      cmd_base_hi <= 32'h00000000;
      cmd_wr_idx <= 8'h00;
      cmd_rd_idx <= 8'h00;
      cmd_run <= 1'b0;
      cmd_irq_en <= 1'b0;
      cmd_size <= SIZE_RESET;
      rsp_base_lo <= 32'h00000000;
      rsp_base_hi <= 32'h00000000;
      rsp_wr_idx <= 8'h00;
      rsp_size <= SIZE_RESET;
      rsp_count_n <= RSP_COUNT_RESET;
      rsp_count <= 8'h00;
      rsp_run <= 1'b0;
      rsp_irq_en <= 1'b0;
      rsp_flag <= 1'b0;
      mem_err_flag <= 1'b0;
      served <= 1'b0;
      avs_readdata <= 32'h00000000;
      state <= st_idle;
      cmd_full <= 1'b0;
      cmd_hold <= NULL_COMMAND;
      rsp_pend <= 1'b0;
      rsp_word <= 32'h00000000;
      rsp_ext <= 5'h00;
    end else begin
      cmd_base_lo <= next_cmd_base_lo;
      cmd_base_hi <= next_cmd_base_hi;
      cmd_wr_idx <= next_cmd_wr_idx;
      cmd_rd_idx <= next_cmd_rd_idx;
      cmd_run <= next_cmd_run;
      cmd_irq_en <= next_cmd_irq_en;
      cmd_size <= next_cmd_size;
      rsp_base_lo <= next_rsp_base_lo;
      rsp_base_hi <= next_rsp_base_hi;
      rsp_wr_idx <= next_rsp_wr_idx;
      rsp_size <= next_rsp_size;
      rsp_count_n <= next_rsp_count_n;
      rsp_count <= next_rsp_count;
      rsp_run <= next_rsp_run;
      rsp_irq_en <= next_rsp_irq_en;
      rsp_flag <= next_rsp_flag;
      mem_err_flag <= next_mem_err_flag;
      served <= next_served;
      avs_readdata <= next_readdata;
      state <= next_state;
      cmd_full <= next_cmd_full;
      cmd_hold <= next_cmd_hold;
      rsp_pend <= next_rsp_pend;
      rsp_word <= next_rsp_word;
      rsp_ext <= next_rsp_ext;
    end
  end
endmodule // verb_ring_dma
`default_nettype wire

// ==== pkg/verb_ring_pkg.sv ====
// constants shared by the command/response ring engine
// assumes a 32-bit avalon-mm slave with word addressing
`default_nettype none
package verb_ring_pkg;
  // register word indices on the avalon bus
  localparam logic [3:0] REG_CMD_BASE_LO = 4'h0;
  localparam logic [3:0] REG_CMD_BASE_HI = 4'h1;
  localparam logic [3:0] REG_CMD_WR_IDX = 4'h2;
  localparam logic [3:0] REG_CMD_RD_IDX = 4'h3;
  localparam logic [3:0] REG_CMD_CTRL = 4'h4;
  localparam logic [3:0] REG_CMD_SIZE = 4'h5;
  localparam logic [3:0] REG_RSP_BASE_LO = 4'h6;
  localparam logic [3:0] REG_RSP_BASE_HI = 4'h7;
  localparam logic [3:0] REG_RSP_WR_IDX = 4'h8;
  localparam logic [3:0] REG_RSP_SIZE = 4'h9;
  localparam logic [3:0] REG_RSP_COUNT = 4'ha;
  localparam logic [3:0] REG_RSP_CTRL = 4'hb;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // control fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_IRQ_EN_BIT = 1;
  localparam int CTRL_IDX_RST_BIT = 2;
  localparam int STAT_RSP_BIT = 0;
  localparam int STAT_MEM_ERR_BIT = 1;
  localparam int IDX_RST_BIT = 15;
  // ring size codes
  localparam logic [1:0] SIZE_2 = 2'h0;
  localparam logic [1:0] SIZE_16 = 2'h1;
  localparam logic [1:0] SIZE_256 = 2'h2;
  localparam logic [3:0] SIZE_CAPABILITY = 4'h7;
  localparam int SIZE_CAP_LSB = 4;
  // reset values
  localparam logic [1:0] SIZE_RESET = SIZE_2;
  localparam logic [7:0] RSP_COUNT_RESET = 8'h01;
  localparam logic [6:0] BASE_ALIGN_ZERO = 7'h00;
  // response extension word layout
  localparam int EXT_SOL_BIT = 4;
  localparam int CMD_BITS = 32;
  localparam logic [31:0] NULL_COMMAND = 32'h00000000;
  typedef enum {st_idle, st_fetch, st_resp_lo, st_resp_hi} dma_state_t;
endpackage
`default_nettype wire

// ==== pkg/link_events_if.sv ====
// frame events and words passed between the link-facing helpers
// assumes all members live in the controller clock domain
`default_nettype none
interface link_events_if;
  logic frame_start;
  logic bit_edge;
  logic resp_present;
  logic resp_unsol;
  logic resp_empty_all;
  logic [3:0] resp_line;
  logic [31:0] resp_word;
  logic [31:0] cmd_word;
  modport rx (output frame_start, bit_edge, resp_present, resp_unsol,
    resp_empty_all, resp_line, resp_word);
  modport ser (input frame_start, bit_edge, cmd_word);
  modport core (input frame_start, resp_present, resp_unsol,
    resp_empty_all, resp_line, resp_word, output cmd_word);
endinterface
`default_nettype wire

// ==== src/link_rx_sync.sv ====
// synchronises link pins and turns them into frame and bit events
// assumes pins stay stable for several clk cycles around sync edges
`default_nettype none
module link_rx_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_bclk,
  input wire logic link_frame_sync,
  input wire logic [31:0] resp_word_pins,
  input wire logic [3:0] resp_line_pins,
  input wire logic resp_unsol_pin,
  input wire logic resp_present_pin,
  input wire logic resp_slot_empty_pin,
  link_events_if.rx ev
);
  localparam int W = 41;
  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic bclk_d;
  logic fsync_d;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  always_comb begin
    next_meta = {link_bclk, link_frame_sync, resp_word_pins,
      resp_line_pins, resp_unsol_pin, resp_present_pin,
      resp_slot_empty_pin};
    next_sync = meta;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      sync <= '0;
      bclk_d <= 1'b0;
      fsync_d <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      bclk_d <= sync[40];
      fsync_d <= sync[39];
    end
  end

  // frame marker taken on its rising edge
  assign ev.frame_start = sync[39] & ~fsync_d;
  assign ev.bit_edge = sync[40] & ~bclk_d;
  assign ev.resp_word = sync[38:7];
  assign ev.resp_line = sync[6:3];
  assign ev.resp_unsol = sync[2];
  assign ev.resp_present = sync[1];
  assign ev.resp_empty_all = sync[0];
endmodule // link_rx_sync
`default_nettype wire

// ==== src/cmd_serializer.sv ====
// shifts one command word out msb first after each frame start
// assumes bit_edge pulses once per link bit clock
`default_nettype none
module cmd_serializer import verb_ring_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  link_events_if.ser ev,
  output logic cmd_sdo
);
  logic [31:0] shreg;
  logic [5:0] left;
  logic [31:0] next_shreg;
  logic [5:0] next_left;
  logic next_sdo;

  always_comb begin
    next_shreg = shreg;
    next_left = left;
    next_sdo = cmd_sdo;
    if (ev.frame_start) begin
      next_shreg = ev.cmd_word;
      next_left = 6'(CMD_BITS);
    end else if (ev.bit_edge && left != 6'h00) begin
      next_sdo = shreg[31];
      next_shreg = {shreg[30:0], 1'b0};
      next_left = left - 6'h01;
    end else if (ev.bit_edge) begin
      next_sdo = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg <= NULL_COMMAND;
      left <= 6'h00;
      cmd_sdo <= 1'b0;
    end else begin
      shreg <= next_shreg;
      left <= next_left;
      cmd_sdo <= next_sdo;
    end
  end
endmodule // cmd_serializer
`default_nettype wire

// ==== tb/verb_ring_dma_chk.sv ====
// port assertions for the command/response ring engine
// assumes one clock domain and synchronous active-low reset
`default_nettype none
module verb_ring_dma_chk import verb_ring_pkg::*; #(
  parameter int AVS_ADDR_W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [AVS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] lo_addr;
  logic rd_done;
  assign rd_done = avs_read && !avs_waitrequest;
  // remembers the response word address so its extension can be paired
  always_ff @(posedge clk) begin
    if (mem_req && mem_write && !mem_addr[2]) lo_addr <= mem_addr;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus wait too long");
  a_wait_first: assert property ($rose(avs_read) |-> avs_waitrequest)
    else $error("read answered without wait");
  a_fetch_align: assert property (mem_req && !mem_write
    |-> mem_addr[1:0] == 2'h0) else $error("fetch not word aligned");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req
    && $stable(mem_addr) && $stable(mem_wdata)) else $error("req moved");
  a_req_gap: assert property (mem_req && mem_ack
    && (!mem_write || mem_addr[2]) |=> !mem_req)
    else $error("no idle between requests");
  a_ext_pair: assert property (mem_req && mem_write && mem_addr[2]
    |-> mem_addr == lo_addr + 64'h4) else $error("extension misplaced");
  a_ext_zero: assert property (mem_req && mem_write && mem_addr[2]
    |-> mem_wdata[31:5] == 27'h0) else $error("extension high bits set");
  a_base_zero: assert property (rd_done && avs_address == REG_CMD_BASE_LO
    |-> avs_readdata[6:0] == 7'h0) else $error("base low bits set");
  a_unmapped_zero: assert property (rd_done && avs_address > 4'hc
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  cover property (mem_req && !mem_write && mem_ack);
  cover property (mem_req && mem_write && mem_ack);
  cover property ($rose(irq));
endmodule // verb_ring_dma_chk
bind verb_ring_dma verb_ring_dma_chk #(.AVS_ADDR_W(AVS_ADDR_W)) chk (
  .clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack,
  .irq);
`default_nettype wire

// ==== tb/host_mem_model.sv ====
// host memory partner: acknowledges each request after lat waits
// assumes the requester holds address and data until the ack edge
`default_nettype none
module host_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [63:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic mem_err,
  output var logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [64];
  logic [63:0] last_addr;
  logic [3:0] cnt;
  assign mem_err = mem_ack && last_addr[7:0] == 8'h84;
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // read data is garbage outside the ack cycle
    mem_rdata <= ~mem_rdata;
    if (!rst_n) begin
      cnt <= 4'h0;
      mem_rdata <= 32'h5a5a5a5a;
    end else if (mem_req && !mem_ack) begin
      if (cnt >= lat) begin
        cnt <= 4'h0;
        mem_ack <= 1'b1;
        last_addr <= mem_addr;
        mem_rdata <= mem[mem_addr[7:2]];
        if (mem_write) mem[mem_addr[7:2]] <= mem_wdata;
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule // host_mem_model
`default_nettype wire

// ==== tb/verb_ring_dma_tb.sv ====
// self-checking bench for verb_ring_dma
// assumes host_mem_model as memory and a bench-driven link
`default_nettype none
module verb_ring_dma_tb import verb_ring_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, mem_req, mem_write;
  logic mem_ack, mem_err, cmd_sdo, irq, link_bclk, link_frame_sync;
  logic resp_unsol_pin, resp_present_pin, resp_slot_empty_pin;
  logic [3:0] avs_address, avs_byteenable, resp_line_pins, lat;
  logic [31:0] avs_writedata, avs_readdata, mem_wdata, mem_rdata, rd;
  logic [31:0] resp_word_pins;
  logic [63:0] mem_addr;
  int n_mismatch = 0, compares = 0, cycles = 0;
  verb_ring_dma dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_err,
    .mem_rdata, .link_bclk, .link_frame_sync, .resp_word_pins,
    .resp_line_pins, .resp_unsol_pin, .resp_present_pin,
    .resp_slot_empty_pin, .cmd_sdo, .irq);
  host_mem_model pm (.clk, .rst_n, .lat, .mem_req, .mem_write, .mem_addr,
    .mem_wdata, .mem_ack, .mem_err, .mem_rdata);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      test_done;
    end
  end
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rdchk(input string what, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask
  task poll(input logic [3:0] a, input logic [31:0] e);
    rd = ~e;
    repeat (100) if (rd !== e) bus(1'b0, a, 32'h0);
  endtask
  task wait_irq;
    repeat (200) if (irq !== 1'b1) @(posedge clk);
  endtask
  // link bit clock runs only inside a frame, 8 clk cycles per bit
  task frame(output logic [31:0] got);
    repeat (5) @(posedge clk);
    link_frame_sync <= 1'b1;
    repeat (8) @(posedge clk);
    link_frame_sync <= 1'b0;
    for (int i = 31; i >= 0; i--) begin
      link_bclk <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk) got[i] = cmd_sdo;
      @(posedge clk);
      link_bclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
  task t_regs;
    rdchk("cmd size", REG_CMD_SIZE, 32'h70);
    bus(1'b1, REG_CMD_SIZE, 32'h3);
    rdchk("size code 3", REG_CMD_SIZE, 32'h70);
    rdchk("rsp count", REG_RSP_COUNT, 32'h1);
    bus(1'b1, REG_CMD_BASE_LO, 32'hffffffff);
    rdchk("cmd base lo", REG_CMD_BASE_LO, 32'hffffff80);
    rdchk("unmapped", 4'hd, 32'h0);
    $display("t_regs done");
  endtask
  task t_cmd;
    logic [31:0] got;
    pm.mem[1] = 32'h1234abcd;
    pm.mem[2] = 32'h80000001;
    bus(1'b1, REG_CMD_CTRL, 32'h4);
    bus(1'b1, REG_CMD_SIZE, 32'h1);
    bus(1'b1, REG_CMD_BASE_LO, 32'h0);
    bus(1'b1, REG_CMD_BASE_HI, 32'h0);
    bus(1'b1, REG_CMD_WR_IDX, 32'h0);
    bus(1'b1, REG_CMD_CTRL, 32'h1);
    bus(1'b1, REG_CMD_WR_IDX, 32'h1);
    poll(REG_CMD_RD_IDX, 32'h1);
    check("rd idx 1", rd, 32'h1);
    check("fetch addr", pm.last_addr[31:0], 32'h4);
    bus(1'b1, REG_CMD_WR_IDX, 32'h2);
    frame(got);
    check("cmd 1", got, 32'h1234abcd);
    poll(REG_CMD_RD_IDX, 32'h2);
    check("rd idx 2", rd, 32'h2);
    frame(got);
    check("cmd 2", got, 32'h80000001);
    frame(got);
    check("idle frame", got, NULL_COMMAND);
    $display("t_cmd done");
  endtask
  task t_rsp;
    logic [31:0] got;
    lat <= 4'h0;
    bus(1'b1, REG_RSP_BASE_LO, 32'h80);
    bus(1'b1, REG_RSP_BASE_HI, 32'h0);
    bus(1'b1, REG_RSP_SIZE, 32'h1);
    bus(1'b1, REG_RSP_COUNT, 32'h1);
    bus(1'b1, REG_RSP_CTRL, 32'h3);
    resp_word_pins <= 32'hcafe0123;
    resp_line_pins <= 4'h5;
    resp_unsol_pin <= 1'b1;
    resp_present_pin <= 1'b1;
    frame(got);
    wait_irq;
    check("irq count", irq, 1'b1);
    check("rsp word", pm.mem[34], 32'hcafe0123);
    check("rsp ext", pm.mem[35], 32'h15);
    rdchk("rsp idx", REG_RSP_WR_IDX, 32'h1);
    bus(1'b1, REG_STATUS, 32'h1);
    @(posedge clk);
    check("irq clear", irq, 1'b0);
    resp_line_pins <= 4'hf;
    resp_unsol_pin <= 1'b0;
    frame(got);
    wait_irq;
    check("sol ext", pm.mem[37], 32'h0f);
    bus(1'b1, REG_STATUS, 32'h1);
    @(posedge clk);
    check("irq clear 2", irq, 1'b0);
    resp_present_pin <= 1'b0;
    resp_slot_empty_pin <= 1'b1;
    frame(got);
    wait_irq;
    check("irq empty", irq, 1'b1);
    $display("t_rsp done");
  endtask
  task t_err;
    bus(1'b1, REG_STATUS, 32'h1);
    bus(1'b1, REG_CMD_CTRL, 32'h6);
    bus(1'b1, REG_CMD_BASE_LO, 32'h80);
    bus(1'b1, REG_CMD_WR_IDX, 32'h1);
    bus(1'b1, REG_CMD_CTRL, 32'h3);
    poll(REG_CMD_RD_IDX, 32'h1);
    check("err idx", rd, 32'h1);
    check("err irq", irq, 1'b1);
    rdchk("err flag", REG_STATUS, 32'h2);
    $display("t_err done");
  endtask
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    lat = 4'h3;
    link_bclk = 1'b0;
    link_frame_sync = 1'b0;
    resp_word_pins = 32'h0;
    resp_line_pins = 4'h0;
    resp_unsol_pin = 1'b0;
    resp_present_pin = 1'b0;
    resp_slot_empty_pin = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_cmd;
    t_rsp;
    t_err;
    test_done;
  end
endmodule // verb_ring_dma_tb
`default_nettype wire
